// ==== logic/snvm_pkg.sv ====
// Types for the serial nonvolatile memory slave port.
// Assumes snvm_regs.svh is on the include path.
`default_nettype none
`include "snvm_regs.svh"

package snvm_pkg;

  // Transfer phase within one selection
  typedef enum logic [3:0] {
    SNVM_CMD, SNVM_ADDR_HI, SNVM_ADDR_LO, SNVM_DUMMY, SNVM_RD, SNVM_WR,
    SNVM_STAT_RD, SNVM_STAT_WR, SNVM_ID_RD, SNVM_IGNORE, SNVM_DONE
  } snvm_phase_e;

  // Pins from the master, other than the clock
  typedef struct packed {
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
  } snvm_pins_s;

  // Per-selection state, cleared while deselected
  typedef struct packed {
    snvm_phase_e               phase;
    logic [2:0]                bit_cnt;
    logic [7:0]                shreg;
    logic [7:0]                cmd;
    logic [`SNVM_ADDR_W-1:0]   addr;
    logic [7:0]                rd_byte;
    logic [1:0]                id_idx;
  } snvm_link_s;

  // State kept across selections
  typedef struct packed {
    logic       wel;
    logic [7:0] status;
    logic       sleep;
  } snvm_keep_s;

  // Output stage, updated on falling clock edges
  typedef struct packed {
    logic so;
    logic drive;
  } snvm_out_s;

  // System clock monitor state
  typedef struct packed {
    logic [1:0]  cs_sync;
    logic        cs_old;
    logic [1:0]  sck_sync;
    logic [1:0]  sleep_sync;
    logic        mode3;
    logic [15:0] frames;
  } snvm_sys_s;

endpackage : snvm_pkg

`default_nettype wire

// ==== logic/snvm_port.sv ====
// Serial slave port of a 16K x 8 nonvolatile byte memory.
// Assumes an SPI master on spi_clk and the pin struct; the system clock
// side only watches the link and reports mode, standby, sleep and the selection count.
//
// How it works
// R1: Sample on rising edge, drive on falling.
// R2: Fully static; clock may stop anytime.
// R3: Deselected: standby, inputs ignored, output floated.
// R4: Internal clocking only while select is low.
// R5: Master drops select before every command.
// R6: Output driven only for read data.
// R7: Protect pin plus enable bit blocks status writes.
// R8: Pause low freezes the transfer.
// R9: Master moves pause only with clock low.
// R10: 16384 bytes, fourteen-bit address.
// R11: Two address bytes, top two bits dropped.
// R12: Writes finish at bus speed, no polling.
// R13: Modes 0 and 3 both supported.
// R14: First byte decoded as command.
// R15: Everything shifted most significant bit first.
// R16: Clock level at select fall picks mode.
// R17: Unknown command: ignore until next selection.
`default_nettype none
`include "snvm_regs.svh"

module snvm_port
  import snvm_pkg::*;
#(
  parameter logic [31:0] ID_WORD = 32'h1234_5678  // Arbitrary identity value
)(
  input  wire logic       sys_clk,    // System clock, 200 MHz
  input  wire logic       rst_n,      // Asynchronous reset, active low
  input  wire logic       spi_clk,    // Serial clock from the master
  input  wire snvm_pins_s spi_in,     // Select, serial in, pause, protect
  output logic            spi_so_o,   // Serial output level
  output logic            spi_so_oe,  // Serial output enable, high drives
  output logic            mode3,      // Last selection began with clock high
  output logic            standby,    // Port deselected
  output logic            sleeping,   // Sleep command taken
  output logic [15:0]     frames      // Selections seen
);

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers

  // Shift one serial bit into the byte, first bit ends up on top
  function automatic logic [7:0] snvm_shift(input logic [7:0] b, input logic s);
    snvm_shift = {b[6:0], s};  // R15
  endfunction : snvm_shift

  // Next memory address, wraps within the array
  function automatic logic [`SNVM_ADDR_W-1:0] snvm_inc(input logic [`SNVM_ADDR_W-1:0] a);
    snvm_inc = a + `SNVM_ADDR_W'(1);
  endfunction : snvm_inc

  // Byte of the identity word picked by an index, top byte first
  function automatic logic [7:0] snvm_id_byte(input logic [1:0] i);
    snvm_id_byte = ID_WORD[8*(3-i) +: 8];  // R15
  endfunction : snvm_id_byte

  ////////////////////////////////////////////////////////////////////////
  // Link clock domain

  logic                    link_rst_n;               // Selection reset
  snvm_link_s              link_q;                   // Per-selection state
  snvm_link_s              link_d;                   // Its next value
  snvm_keep_s              keep_q;                   // Kept state
  snvm_keep_s              keep_d;                   // Its next value
  snvm_out_s               out_q;                    // Falling edge stage
  snvm_out_s               out_d;                    // Its next value
  logic [7:0]              mem [`SNVM_DEPTH];        // Byte array
  logic                    mem_we;                   // Array write strobe
  logic [`SNVM_ADDR_W-1:0] mem_wa;                   // Array write address
  logic [7:0]              mem_wd;                   // Array write data
  logic [7:0]              byte_v;                   // Byte with current bit
  logic [`SNVM_ADDR_W-1:0] addr_v;                   // Address just completed
  logic                    read_phase;               // Phase that returns data

  // Deselect clears the transfer; the clock only counts while selected
  assign link_rst_n = rst_n & ~spi_in.cs_n;  // R3 R4

  // Byte formed by the bit on the serial input this edge
  assign byte_v = snvm_shift(link_q.shreg, spi_in.si);

  // Address from the kept high part and the newest byte, top bits dropped
  assign addr_v = {link_q.addr[`SNVM_ADDR_W-1:8], byte_v};  // R11

  // Phases whose bytes go out on the serial output
  assign read_phase = (link_q.phase == SNVM_RD) || (link_q.phase == SNVM_STAT_RD) ||
                      (link_q.phase == SNVM_ID_RD);

  // Rising edge next state: decode, address and data handling
  always_comb
  begin
    link_d = link_q;
    keep_d = keep_q;
    mem_we = 1'b0;
    mem_wa = link_q.addr;
    mem_wd = byte_v;
    // Pause or deselect freezes everything; stray edges while deselected
    // must not wake a sleeping part
    if (spi_in.hold_n && !spi_in.cs_n)  // R8 R9 R3 R4
    begin
      link_d.bit_cnt = link_q.bit_cnt + 3'h1;
      link_d.shreg   = byte_v;  // R1
      // First edge of a selection wakes the part
      if (link_q.phase == SNVM_CMD && link_q.bit_cnt == 3'h0)
      begin
        keep_d.sleep = 1'b0;
      end
      if (link_q.bit_cnt == `SNVM_LAST_BIT)
      begin
        unique case (link_q.phase)
          // Command byte
          SNVM_CMD:  // R14 R5
          begin
            link_d.cmd = byte_v;
            unique case (byte_v)
              `SNVM_OP_SET_WL:
              begin
                keep_d.wel   = 1'b1;
                link_d.phase = SNVM_DONE;
              end
              `SNVM_OP_CLR_WL:
              begin
                keep_d.wel   = 1'b0;
                link_d.phase = SNVM_DONE;
              end
              `SNVM_OP_STAT_RD:
              begin
                link_d.rd_byte = keep_q.status;
                link_d.phase   = SNVM_STAT_RD;
              end
              `SNVM_OP_STAT_WR:
              begin
                link_d.phase = SNVM_STAT_WR;
              end
              `SNVM_OP_READ, `SNVM_OP_QREAD, `SNVM_OP_WRITE:
              begin
                link_d.phase = SNVM_ADDR_HI;
              end
              `SNVM_OP_SLEEP:
              begin
                keep_d.sleep = 1'b1;
                link_d.phase = SNVM_DONE;
              end
              `SNVM_OP_ID_RD:
              begin
                link_d.rd_byte = snvm_id_byte(2'h0);
                link_d.id_idx  = 2'h1;
                link_d.phase   = SNVM_ID_RD;
              end
              default:
              begin
                link_d.phase = SNVM_IGNORE;  // R17
              end
            endcase
          end
          // High address byte, two top bits dropped
          SNVM_ADDR_HI:
          begin
            link_d.addr[`SNVM_ADDR_W-1:8] = byte_v[`SNVM_ADDR_HI_W-1:0];  // R11
            link_d.phase = SNVM_ADDR_LO;
          end
          // Low address byte, then branch on the command
          SNVM_ADDR_LO:
          begin
            link_d.addr = addr_v;  // R10
            if (link_q.cmd == `SNVM_OP_WRITE)
            begin
              link_d.phase = SNVM_WR;
            end
            else if (link_q.cmd == `SNVM_OP_QREAD)
            begin
              link_d.phase = SNVM_DUMMY;
            end
            else
            begin
              link_d.rd_byte = mem[addr_v];
              link_d.addr    = snvm_inc(addr_v);
              link_d.phase   = SNVM_RD;
            end
          end
          // Dummy byte of the quick read
          SNVM_DUMMY:
          begin
            link_d.rd_byte = mem[link_q.addr];
            link_d.addr    = snvm_inc(link_q.addr);
            link_d.phase   = SNVM_RD;
          end
          // Sequential read, next byte ready before its first falling edge
          SNVM_RD:
          begin
            link_d.rd_byte = mem[link_q.addr];
            link_d.addr    = snvm_inc(link_q.addr);
          end
          // Sequential write, stored on the last bit's edge
          SNVM_WR:
          begin
            mem_we      = keep_q.wel;  // R12
            link_d.addr = snvm_inc(link_q.addr);
          end
          // Status read repeats the status byte
          SNVM_STAT_RD:
          begin
            link_d.rd_byte = keep_q.status;
          end
          // Status write, refused while protected
          SNVM_STAT_WR:
          begin
            if (keep_q.wel &&
                !(!spi_in.wp_n && keep_q.status[`SNVM_PROT_EN_BIT]))  // R7
            begin
              keep_d.status = byte_v;
            end
            link_d.phase = SNVM_DONE;
          end
          // Identity bytes in turn
          SNVM_ID_RD:
          begin
            link_d.rd_byte = snvm_id_byte(link_q.id_idx);
            link_d.id_idx  = link_q.id_idx + 2'h1;
          end
          // Unknown command or finished: input ignored
          SNVM_IGNORE, SNVM_DONE:
          begin
            link_d.phase = link_q.phase;  // R17
          end
        endcase
      end
    end
  end

  // Rising edge register of per-selection state
  always_ff @(posedge spi_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      link_q <= '{phase: SNVM_CMD, default: '0};  // R3
    end
    else
    begin
      link_q <= link_d;  // R1 R2
    end
  end

  // Rising edge register of kept state
  always_ff @(posedge spi_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      keep_q <= '{wel: 1'b0, status: `SNVM_STATUS_RST, sleep: 1'b0};
    end
    else
    begin
      keep_q <= keep_d;
    end
  end

  // Array write port, no reset on the stored bytes
  always_ff @(posedge spi_clk)
  begin
    if (mem_we)
    begin
      mem[mem_wa] <= mem_wd;  // R10 R12
    end
  end

  // Falling edge next state: data bit out, top bit first
  always_comb
  begin
    out_d = out_q;
    if (spi_in.hold_n)  // R8
    begin
      out_d.so    = link_q.rd_byte[~link_q.bit_cnt];  // R15
      out_d.drive = read_phase;  // R6
    end
  end

  // Falling edge register; in mode 3 the first fall finds no read phase
  always_ff @(negedge spi_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      out_q <= '0;
    end
    else
    begin
      out_q <= out_d;  // R1 R13
    end
  end

  // Output floats while paused or deselected
  assign spi_so_o  = out_q.so;
  assign spi_so_oe = out_q.drive & spi_in.hold_n & ~spi_in.cs_n;  // R3 R6

  ////////////////////////////////////////////////////////////////////////
  // System clock domain monitor

  snvm_sys_s sys_q;  // Monitor state
  snvm_sys_s sys_d;  // Its next value

  // Synchronise pins, catch select fall and the clock level at it
  always_comb
  begin
    sys_d            = sys_q;
    sys_d.cs_sync    = {sys_q.cs_sync[0], spi_in.cs_n};
    sys_d.sck_sync   = {sys_q.sck_sync[0], spi_clk};
    sys_d.sleep_sync = {sys_q.sleep_sync[0], keep_q.sleep};
    sys_d.cs_old     = sys_q.cs_sync[1];
    // Select fall seen on the settled copy
    if (sys_q.cs_old && !sys_q.cs_sync[1])
    begin
      sys_d.mode3  = sys_q.sck_sync[1];  // R16 R13
      sys_d.frames = sys_q.frames + 16'h0001;
    end
  end

  // Monitor register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_q <= '{cs_sync: 2'h3, cs_old: 1'b1, default: '0};
    end
    else
    begin
      sys_q <= sys_d;
    end
  end

  // Monitor outputs, all from flip-flops
  assign mode3    = sys_q.mode3;
  assign standby  = sys_q.cs_sync[1];  // R3
  assign sleeping = sys_q.sleep_sync[1];
  assign frames   = sys_q.frames;

endmodule : snvm_port

`default_nettype wire

// ==== logic/snvm_regs.svh ====
// Constants for the serial nonvolatile memory slave port.
// Assumes inclusion by bare name from the package and the port module.
`ifndef SNVM_REGS_SVH
`define SNVM_REGS_SVH

// Memory organisation
`define SNVM_ADDR_W        14
`define SNVM_DEPTH         16384
`define SNVM_ADDR_HI_W     6

// Command bytes
`define SNVM_OP_SET_WL     8'h06
`define SNVM_OP_CLR_WL     8'h04
`define SNVM_OP_STAT_RD    8'h05
`define SNVM_OP_STAT_WR    8'h01
`define SNVM_OP_READ       8'h03
`define SNVM_OP_QREAD      8'h0b
`define SNVM_OP_WRITE      8'h02
`define SNVM_OP_SLEEP      8'hb9
`define SNVM_OP_ID_RD      8'h9f

// Status field position, status reset value and last bit index of a byte
`define SNVM_PROT_EN_BIT   7
`define SNVM_STATUS_RST    8'h00
`define SNVM_LAST_BIT      3'h7

// Link clock limit, for reference by the bench
`define SNVM_SCK_MAX_MHZ   40

`endif

// ==== verification/snvm_master.sv ====
// SPI master model facing the slave port; it makes the 6 ns link clock.
// Assumes snvm_pkg is compiled first; the bench calls its tasks by hierarchy.
`default_nettype none

module snvm_master
  import snvm_pkg::*;
(
  output var logic       sck,   // Link clock, still outside frames
  output var snvm_pins_s pins,  // Select, serial in, pause, protect
  input  wire logic      so_o,  // Serial output level from the port
  input  wire logic      so_oe  // Serial output enable from the port
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam time HALF = 3ns;  // Half of the link period
  logic           m3;          // Mode of the current frame

  ////////////////////////////////////////////////////////////////////////
  // Idle pins: deselected, not paused, unprotected
  initial
  begin
    sck  = 1'b0;
    m3   = 1'b0;
    pins = '{cs_n: 1'b1, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
  end

  // Park the clock at the mode's idle level, then select
  task automatic sel(input logic mode);
    m3  = mode;
    sck = mode;
    #(2*HALF);
    pins.cs_n = 1'b0;
    #(2*HALF);
  endtask : sel

  // One byte, MSB first; input set with clock low, output taken at the rise
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck     = 1'b0;
      pins.si = tx[i];
      #HALF;
      sck   = 1'b1;
      rx[i] = so_oe ? so_o : 1'bz;  // Floating line reads as high impedance
      #HALF;
    end
  endtask : xb

  // Clock back to idle level, then release select
  task automatic desel();
    #HALF;
    sck = m3;
    #HALF;
    pins.cs_n = 1'b1;
    #(2*HALF);
  endtask : desel

  // Pause with the clock low, toggle the clock while paused, resume
  task automatic pause(output logic oe_seen);
    sck = 1'b0;
    #HALF;
    pins.hold_n = 1'b0;
    repeat (3)
    begin
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
    end
    oe_seen = so_oe;
    #HALF;
    pins.hold_n = 1'b1;
    #HALF;
  endtask : pause

  // Write-protect pin level
  task automatic set_wp(input logic v);
    pins.wp_n = v;
  endtask : set_wp
endmodule : snvm_master

`default_nettype wire

// ==== verification/snvm_port_monitor.sv ====
// Concurrent checks on the slave port's pins and monitor outputs.
// Assumes snvm_pkg; attached to every snvm_port by the bind at the foot.
`default_nettype none

module snvm_port_monitor
  import snvm_pkg::*;
(
  input wire logic        sys_clk,    // System clock
  input wire logic        rst_n,      // Asynchronous reset, active low
  input wire logic        spi_clk,    // Link clock
  input wire snvm_pins_s  spi_in,     // Pins from the master
  input wire logic        spi_so_o,   // Serial output level
  input wire logic        spi_so_oe,  // Serial output enable
  input wire logic        mode3,      // Mode of last selection
  input wire logic        standby,    // Deselected flag
  input wire logic        sleeping,   // Sleep flag
  input wire logic [15:0] frames      // Selection count
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Output stage floats when deselected or paused
  a_desel_float: assert property (spi_in.cs_n |-> !spi_so_oe)
    else $error("Output enabled while deselected");
  a_pause_float: assert property (!spi_in.hold_n |-> !spi_so_oe)
    else $error("Output enabled while paused");
  a_oe_selected: assert property (spi_so_oe |-> !standby)
    else $error("Output enabled in standby");
  // Mode picked from the clock level at select fall
  a_mode3_pick: assert property ($fell(spi_in.cs_n) && spi_clk |-> ##[1:8] mode3)
    else $error("Mode 3 not taken");
  a_mode0_pick: assert property ($fell(spi_in.cs_n) && !spi_clk |-> ##[1:8] !mode3)
    else $error("Mode 0 not taken");
  // Each selection counted once, nothing counted while idle
  a_frame_count: assert property ($fell(spi_in.cs_n) |-> ##[1:8] $changed(frames))
    else $error("Selection not counted");
  a_frame_step: assert property ($changed(frames) |-> frames == $past(frames) + 16'h1)
    else $error("Selection count jumped");
  a_frame_idle: assert property (spi_in.cs_n [*6] |-> $stable(frames))
    else $error("Count moved while deselected");
  // Standby follows select within the sync delay
  a_standby_high: assert property (spi_in.cs_n [*5] |-> standby)
    else $error("Standby missing");
  a_standby_low: assert property (!spi_in.cs_n [*5] |-> !standby)
    else $error("Standby while selected");
endmodule : snvm_port_monitor

bind snvm_port snvm_port_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk),
  .spi_in(spi_in), .spi_so_o(spi_so_o), .spi_so_oe(spi_so_oe), .mode3(mode3),
  .standby(standby), .sleeping(sleeping), .frames(frames));

`default_nettype wire

// ==== verification/snvm_port_tb_top.sv ====
// Bench for the serial memory slave port; the master model drives the link.
// Assumes snvm_pkg, the port, the master model and the checker are compiled.
`default_nettype none

module snvm_port_tb_top
  import snvm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] ID_T = 32'h9e37_c1d4;  // Arbitrary identity value
  logic        sys_clk;     // System clock
  logic        rst_n;       // Reset, active low
  logic        spi_clk;     // Link clock from the master
  snvm_pins_s  spi_in;      // Master pins
  logic        so_o;        // Serial output level
  logic        so_oe;       // Serial output enable
  logic        mode3;       // Mode flag
  logic        standby;     // Standby flag
  logic        sleeping;    // Sleep flag
  logic [15:0] frames;      // Selection count
  logic [7:0]  rx;          // Last byte received
  logic        oe_p;        // Enable seen while paused
  int          num_errors;  // Mismatches
  int          n_tests;     // Comparisons

  snvm_port #(.ID_WORD(ID_T)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk),
    .spi_in(spi_in), .spi_so_o(so_o), .spi_so_oe(so_oe), .mode3(mode3),
    .standby(standby), .sleeping(sleeping), .frames(frames));
  snvm_master u_mst (.sck(spi_clk), .pins(spi_in), .so_o(so_o), .so_oe(so_oe));

  ////////////////////////////////////////////////////////////////////////
  // 200 MHz system clock
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Byte exchange on the link
  task automatic b(input logic [7:0] tx);
    u_mst.xb(tx, rx);
  endtask : b

  // Single-byte command frame
  task automatic cmd1(input logic [7:0] op);
    u_mst.sel(1'b0);
    b(op);
    u_mst.desel();
  endtask : cmd1

  // Status read and write frames
  task automatic stat_rd(input logic [7:0] exp);
    u_mst.sel(1'b0);
    b(8'h05);
    b(8'h00);
    chk(16'(rx), 16'(exp));
    u_mst.desel();
  endtask : stat_rd
  task automatic stat_wr(input logic [7:0] v);
    cmd1(8'h06);
    u_mst.sel(1'b0);
    b(8'h01);
    b(v);
    u_mst.desel();
  endtask : stat_wr

  // Memory read of one byte at a 16-bit address
  task automatic rd_at(input logic m, input logic [15:0] a, input logic [7:0] exp);
    u_mst.sel(m);
    b(8'h03);
    b(a[15:8]);
    b(a[7:0]);
    b(8'h00);
    chk(16'(rx), 16'(exp));
    u_mst.desel();
  endtask : rd_at

  // Reset values, then status bits, wrap-around writes and a refused write
  task automatic t_basic();
    chk({14'h0, standby, so_oe}, 16'h2);
    chk(frames, 16'h0);
    stat_rd(8'h00);
    cmd1(8'h06);
    u_mst.sel(1'b0);
    b(8'h02);
    b(8'hff);
    b(8'hff);
    b(8'ha5);
    b(8'h5a);
    u_mst.desel();
    rd_at(1'b1, 16'h3fff, 8'ha5);
    chk(16'(mode3), 16'h1);
    rd_at(1'b0, 16'hc000, 8'h5a);
    cmd1(8'h04);
    cmd1(8'h02);
    u_mst.sel(1'b0);
    b(8'h02);
    b(8'h00);
    b(8'h00);
    b(8'hff);
    u_mst.desel();
    rd_at(1'b0, 16'h0000, 8'h5a);
    $display("t_basic done");
  endtask : t_basic

  // Status protection through pin and enable bit
  task automatic t_status();
    stat_wr(8'h80);
    stat_rd(8'h80);
    u_mst.set_wp(1'b0);
    stat_wr(8'h00);
    stat_rd(8'h80);
    u_mst.set_wp(1'b1);
    stat_wr(8'h0c);
    stat_rd(8'h0c);
    $display("t_status done");
  endtask : t_status

  // Quick read, identity wrap, pause mid-read
  task automatic t_reads();
    u_mst.sel(1'b0);
    b(8'h0b);
    b(8'h00);
    b(8'h00);
    b(8'h00);
    b(8'h00);
    chk(16'(rx), 16'h5a);
    u_mst.desel();
    u_mst.sel(1'b1);
    b(8'h9f);
    for (int k = 0; k < 5; k++)
    begin
      b(8'h00);
      chk(16'(rx), 16'(ID_T[31-8*(k%4) -: 8]));
    end
    u_mst.desel();
    u_mst.sel(1'b0);
    b(8'h03);
    b(8'h3f);
    b(8'hff);
    b(8'h00);
    u_mst.pause(oe_p);
    chk(16'(oe_p), 16'h0);
    b(8'h00);
    chk(16'(rx), 16'h5a);
    u_mst.desel();
    $display("t_reads done");
  endtask : t_reads

  // Unknown command floats the output; sleep flag set and cleared
  task automatic t_odd();
    u_mst.sel(1'b0);
    b(8'hc3);
    b(8'h05);
    b(8'h00);
    chk(16'(rx), 16'h00zz);
    u_mst.desel();
    cmd1(8'hb9);
    for (int i = 0; i < 20 && sleeping !== 1'b1; i++)
      @(posedge sys_clk);
    chk(16'(sleeping), 16'h1);
    stat_rd(8'h0c);
    for (int i = 0; i < 20 && sleeping !== 1'b0; i++)
      @(posedge sys_clk);
    chk(16'(sleeping), 16'h0);
    chk(frames, 16'h18);
    $display("t_odd done");
  endtask : t_odd

  // Mode 3 sleep frame, then a reset in mid-run clears monitor and status
  task automatic t_reset();
    u_mst.sel(1'b1);
    b(8'hb9);
    u_mst.desel();
    for (int i = 0; i < 20 && sleeping !== 1'b1; i++)
      @(posedge sys_clk);
    chk({14'h0, mode3, sleeping}, 16'h3);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({12'h0, mode3, sleeping, standby, so_oe}, 16'h2);
    chk(frames, 16'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    stat_rd(8'h00);
    chk(frames, 16'h1);
    $display("t_reset done");
  endtask : t_reset

  // Counts and verdict
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial
  begin
    rst_n      = 1'b0;
    num_errors = 0;
    n_tests    = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_basic();
    t_status();
    t_reads();
    t_odd();
    t_reset();
    tally_and_finish();
  end

  // Watchdog, far beyond the expected run
  initial
  begin
    #100us;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : snvm_port_tb_top

`default_nettype wire
